// >>> sltc_pkg.sv
// Purpose: constants and types for the serial link transmit configuration
// Assumes: eight-bit register port on the serial control port side
// Notes: K field holds frames per multiframe minus one
package sltc_pkg;
   localparam logic [7:0] ADDR_SYNC = 8'h3A;
   localparam logic [7:0] ADDR_QUICK = 8'h5E;
   localparam logic [7:0] ADDR_LANE_ASG = 8'h5F;
   localparam logic [7:0] ADDR_CTL1 = 8'h60;
   localparam logic [7:0] ADDR_CTL2 = 8'h61;
   localparam logic [7:0] ADDR_CTL3 = 8'h62;
   localparam logic [7:0] ADDR_REPEAT = 8'h63;
   localparam logic [7:0] ADDR_DID = 8'h64;
   localparam logic [7:0] ADDR_BID = 8'h65;
   localparam logic [7:0] ADDR_LID0 = 8'h66;
   localparam logic [7:0] ADDR_LID1 = 8'h67;
   localparam logic [7:0] ADDR_SCR = 8'h6E;
   localparam logic [7:0] ADDR_F = 8'h6F;
   localparam logic [7:0] ADDR_K = 8'h70;
   localparam logic [7:0] ADDR_M = 8'h71;
   // reset values
   localparam logic [7:0] RST_SCR = 8'h80;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [4:0] RST_K = 5'h0F;
   // quick configure codes
   localparam logic [2:0] QC_NONE = 3'h0;
   localparam logic [2:0] QC_TWO_LINKS = 3'h1;
   localparam logic [2:0] QC_ONE_LINK_TWO_LANES = 3'h2;
   localparam logic [2:0] QC_ONE_LINK_ONE_LANE = 3'h3;
   localparam logic [3:0] LANE_ASG_DIRECT = 4'h0;
   localparam logic [3:0] LANE_ASG_TWO_LANE_A = 4'h2;
   localparam logic [3:0] LANE_ASG_MAX = 4'h5;
   localparam logic [7:0] QC_CTL1_TWO_LANES = 8'h14;
   localparam logic [7:0] QC_CTL2_GLOBAL = 8'h40;
   localparam logic [4:0] K_16 = 5'h0F;
   localparam logic [4:0] K_8 = 5'h07;
   localparam logic [7:0] F_TWO = 8'h02;
   localparam logic [7:0] F_FOUR = 8'h04;
   localparam logic [1:0] ILAS_RESERVED = 2'h2;
   localparam logic [1:0] INJ_SAMPLE = 2'h0;
   localparam logic [1:0] INJ_SYMBOL = 2'h1;
   // sync request modes
   localparam logic [1:0] SREQ_OWN = 2'h0;
   localparam logic [1:0] SREQ_ANY = 2'h1;
   localparam logic [1:0] SREQ_FORCE = 2'h2;
   // test generator modes
   localparam logic [2:0] TG_NORMAL = 3'h0;
   localparam logic [2:0] TG_CHECKER = 3'h1;
   localparam logic [2:0] TG_TOGGLE = 3'h2;
   localparam logic [2:0] TG_PN_LONG = 3'h3;
   localparam logic [2:0] TG_PN_SHORT = 3'h4;
   localparam logic [2:0] TG_USER_REPEAT = 3'h5;
   localparam logic [2:0] TG_USER_ONCE = 3'h6;
   localparam logic [2:0] TG_RAMP = 3'h7;
   localparam logic [15:0] TG_CHECK_WORD = 16'hAAAA;
   localparam logic [15:0] TG_ONES = 16'hFFFF;
   localparam logic [15:0] USER_PAT1 = 16'h1111;
   localparam logic [15:0] USER_PAT2 = 16'h2222;
   localparam logic [15:0] USER_PAT3 = 16'h3333;
   localparam logic [15:0] USER_PAT4 = 16'h4444;
   localparam logic [30:0] LFSR_SEED = 31'h7FFFFFFF;
   localparam logic [8:0] PN9_SEED = 9'h1FF;

   typedef struct packed {
      logic tail_en;
      logic test_sample_en;
      logic lane_sync_en;
      logic [1:0] ilas_mode;
      logic fac_disable;
      logic powered_down;
      logic cmos_sel;
      logic bypass;
      logic invert;
      logic mirror;
      logic chk_disable;
      logic [1:0] inject_sel;
      logic [2:0] test_mode;
      logic [7:0] ilas_repeat;
      logic [7:0] device_id;
      logic [3:0] bank_id;
      logic [4:0] lane0_id;
      logic [4:0] lane1_id;
      logic scrambler_enable;
      logic two_lanes;
      logic two_conv;
      logic [4:0] k_minus_one;
      logic [3:0] lane_assign;
   } sltc_link_cfg_type;
endpackage

// >>> sltc_sync_rx.sv
// Purpose: far-end link receiver raising the two sync request pins
// Assumes: requests are levels, moved just after a clock edge
// Notes: active low unless the device is set to invert its input
`timescale 1ns/1ps
module sltc_sync_rx (
   input wire logic i_clock,
   input wire logic i_want_a,
   input wire logic i_want_b,
   input wire logic i_active_high,
   output logic o_req_a,
   output logic o_req_b
);
   initial begin
      o_req_a = 1'b1;
      o_req_b = 1'b1;
   end
   // pins are always driven, idle means deasserted
   always @(posedge i_clock) begin
      o_req_a <= i_active_high ? i_want_a : ~i_want_a;
      o_req_b <= i_active_high ? i_want_b : ~i_want_b;
   end
endmodule

// >>> sltc_top.sv
// Purpose: serial link transmit configuration, sync and test generation
// Assumes: register port already decoded from the serial control port
// Notes: sync and sync request pin inputs pass a three-stage synchroniser
`timescale 1ns/1ps
module sltc_top (
   input wire logic I_CLOCK,
   input wire logic I_RST_N,
   input wire logic [7:0] I_REG_ADDR,
   input wire logic [7:0] I_REG_WDATA,
   input wire logic I_REG_WE,
   input wire logic I_REG_RE,
   input wire logic I_SYNC_PIN,
   input wire logic I_LINK_A_SYNC_REQUEST,
   input wire logic I_LINK_B_SYNC_REQUEST,
   input wire logic [7:0] I_OCTET,
   input wire logic [9:0] I_ENC_SYMBOL,
   output logic [7:0] O_REG_RDATA,
   output logic O_DIV_SYNC,
   output logic O_CGS_A,
   output logic O_CGS_B,
   output logic O_LINK_RESET,
   output logic O_TAIL_BIT,
   output logic [9:0] O_LANE_A_SERIAL_OUT,
   output logic [15:0] O_TEST_WORD,
   output logic O_TEST_AT_SYMBOL,
   output sltc_pkg::sltc_link_cfg_type O_LINK_CFG
);
   logic [1:0] rst_sync;
   logic rst_n;
   logic [2:0] sync_ctrl;
   logic [3:0] lane_asg;
   logic [6:0] ctl1;
   logic [7:0] ctl2;
   logic [7:0] ctl3;
   logic [7:0] repeat_cnt;
   logic [7:0] link_device_id;
   logic [3:0] link_bank_id;
   logic [4:0] lid0;
   logic [4:0] lid1;
   logic scr_en;
   logic two_lanes;
   logic [4:0] kreg;
   logic two_conv;
   logic [2:0] sp_q;
   logic sp_lvl;
   logic [2:0] ra_q;
   logic [2:0] rb_q;
   logic ra_lvl;
   logic rb_lvl;
   logic [30:0] lfsr;
   logic [8:0] pn9;
   logic [15:0] ramp;
   logic [1:0] pat_idx;
   logic pat_done;
   logic tg_phase;
   logic wr;
   logic [2:0] qc;
   logic sync_edge;
   logic req_a;
   logic req_b;
   logic [9:0] sym;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      return a == r;
   endfunction

   function automatic logic [7:0] f_calc(input logic m2, input logic l2);
      return (m2 && !l2) ? sltc_pkg::F_FOUR : sltc_pkg::F_TWO;
   endfunction

   // reset release through two flip-flops
   always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   assign wr = I_REG_WE;
   assign qc = I_REG_WDATA[2:0];

   // pin synchronisers; level moves only when stages two and three agree
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         sp_q <= 3'h0;
         ra_q <= 3'h7;
         rb_q <= 3'h7;
         sp_lvl <= 1'b0;
         ra_lvl <= 1'b1;
         rb_lvl <= 1'b1;
      end else begin
         sp_q <= {sp_q[1:0], I_SYNC_PIN};
         ra_q <= {ra_q[1:0], I_LINK_A_SYNC_REQUEST};
         rb_q <= {rb_q[1:0], I_LINK_B_SYNC_REQUEST};
         if (sp_q[1] == sp_q[2]) begin
            sp_lvl <= sp_q[2];
         end
         if (ra_q[1] == ra_q[2]) begin
            ra_lvl <= ra_q[2];
         end
         if (rb_q[1] == rb_q[2]) begin
            rb_lvl <= rb_q[2];
         end
      end
   end

   assign sync_edge = sp_q[1] && sp_q[2] && !sp_lvl;

   // sync control; hardware self-clear of the divider enable
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         sync_ctrl <= 3'h0;
         O_DIV_SYNC <= 1'b0;
      end else begin
         O_DIV_SYNC <= sync_edge && sync_ctrl[1] && sync_ctrl[0];
         if (wr && hit(I_REG_ADDR, sltc_pkg::ADDR_SYNC)) begin
            sync_ctrl <= I_REG_WDATA[2:0];
         end else if (sync_edge && (&sync_ctrl)) begin
            sync_ctrl[1] <= 1'b0;
         end
      end
   end

   // link configuration registers with quick configure presets
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         lane_asg <= sltc_pkg::LANE_ASG_DIRECT;
         ctl1 <= 7'h00;
         ctl2 <= sltc_pkg::RST_ZERO;
         ctl3 <= sltc_pkg::RST_ZERO;
         repeat_cnt <= sltc_pkg::RST_ZERO;
         link_device_id <= sltc_pkg::RST_ZERO;
         link_bank_id <= 4'h0;
         lid0 <= 5'h00;
         lid1 <= 5'h00;
         scr_en <= sltc_pkg::RST_SCR[7];
         two_lanes <= sltc_pkg::RST_SCR[0];
         kreg <= sltc_pkg::RST_K;
         two_conv <= 1'b0;
      end else if (wr) begin
         case (I_REG_ADDR)
            sltc_pkg::ADDR_QUICK: begin
               case (qc)
                  sltc_pkg::QC_TWO_LINKS: begin
                     lane_asg <= sltc_pkg::LANE_ASG_DIRECT;
                     two_conv <= 1'b0;
                     two_lanes <= 1'b0;
                     kreg <= sltc_pkg::K_16;
                  end
                  sltc_pkg::QC_ONE_LINK_TWO_LANES: begin
                     lane_asg <= sltc_pkg::LANE_ASG_TWO_LANE_A;
                     ctl1 <= sltc_pkg::QC_CTL1_TWO_LANES[6:0];
                     two_conv <= 1'b1;
                     two_lanes <= 1'b1;
                     kreg <= sltc_pkg::K_16;
                  end
                  sltc_pkg::QC_ONE_LINK_ONE_LANE: begin
                     lane_asg <= sltc_pkg::LANE_ASG_DIRECT;
                     ctl2 <= sltc_pkg::QC_CTL2_GLOBAL;
                     two_conv <= 1'b1;
                     two_lanes <= 1'b0;
                     kreg <= sltc_pkg::K_8;
                  end
                  default: begin
                     lane_asg <= lane_asg;
                  end
               endcase
            end
            sltc_pkg::ADDR_LANE_ASG: begin
               if (I_REG_WDATA[3:0] <= sltc_pkg::LANE_ASG_MAX) begin
                  lane_asg <= I_REG_WDATA[3:0];
               end
            end
            sltc_pkg::ADDR_CTL1: begin
               if (I_REG_WDATA[3:2] != sltc_pkg::ILAS_RESERVED) begin
                  ctl1 <= I_REG_WDATA[6:0];
               end
            end
            sltc_pkg::ADDR_CTL2: begin
               ctl2 <= {I_REG_WDATA[7:4], 1'b0, I_REG_WDATA[2:0]};
            end
            sltc_pkg::ADDR_CTL3: begin
               if (!I_REG_WDATA[5]) begin
                  ctl3 <= {I_REG_WDATA[7], 1'b0, I_REG_WDATA[5:4], 1'b0,
                           I_REG_WDATA[2:0]};
               end
            end
            sltc_pkg::ADDR_REPEAT: repeat_cnt <= I_REG_WDATA;
            sltc_pkg::ADDR_DID: link_device_id <= I_REG_WDATA;
            sltc_pkg::ADDR_BID: link_bank_id <= I_REG_WDATA[3:0];
            sltc_pkg::ADDR_LID0: lid0 <= I_REG_WDATA[4:0];
            sltc_pkg::ADDR_LID1: lid1 <= I_REG_WDATA[4:0];
            sltc_pkg::ADDR_K: kreg <= I_REG_WDATA[4:0];
            sltc_pkg::ADDR_M: two_conv <= I_REG_WDATA[0];
            sltc_pkg::ADDR_SCR: begin
               scr_en <= I_REG_WDATA[7];
               two_lanes <= I_REG_WDATA[0];
            end
            default: begin
               kreg <= kreg;
            end
         endcase
      end
   end

   // register read; quick configure and unmapped addresses read zero
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         O_REG_RDATA <= sltc_pkg::RST_ZERO;
      end else if (I_REG_RE) begin
         case (I_REG_ADDR)
            sltc_pkg::ADDR_SYNC: O_REG_RDATA <= {5'h00, sync_ctrl};
            sltc_pkg::ADDR_LANE_ASG: O_REG_RDATA <= {4'h0, lane_asg};
            sltc_pkg::ADDR_CTL1: O_REG_RDATA <= {1'b0, ctl1};
            sltc_pkg::ADDR_CTL2: O_REG_RDATA <= ctl2;
            sltc_pkg::ADDR_CTL3: O_REG_RDATA <= ctl3;
            sltc_pkg::ADDR_REPEAT: O_REG_RDATA <= repeat_cnt;
            sltc_pkg::ADDR_DID: O_REG_RDATA <= link_device_id;
            sltc_pkg::ADDR_BID: O_REG_RDATA <= {4'h0, link_bank_id};
            sltc_pkg::ADDR_LID0: O_REG_RDATA <= {3'h0, lid0};
            sltc_pkg::ADDR_LID1: O_REG_RDATA <= {3'h0, lid1};
            sltc_pkg::ADDR_SCR: O_REG_RDATA <= {scr_en, 6'h00, two_lanes};
            sltc_pkg::ADDR_F: O_REG_RDATA <= f_calc(two_conv, two_lanes);
            sltc_pkg::ADDR_K: O_REG_RDATA <= {3'h0, kreg};
            sltc_pkg::ADDR_M: O_REG_RDATA <= {7'h00, two_conv};
            default: O_REG_RDATA <= sltc_pkg::RST_ZERO;
         endcase
      end
   end

   // code group sync requests; pins are active low unless inverted
   assign req_a = ra_lvl ~^ ctl2[5];
   assign req_b = rb_lvl ~^ ctl2[5];

   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         O_CGS_A <= 1'b0;
         O_CGS_B <= 1'b0;
      end else if (ctl1[0]) begin
         O_CGS_A <= 1'b0;
         O_CGS_B <= 1'b0;
      end else begin
         case (ctl2[7:6])
            sltc_pkg::SREQ_OWN: begin
               O_CGS_A <= req_a;
               O_CGS_B <= req_b;
            end
            sltc_pkg::SREQ_ANY: begin
               O_CGS_A <= req_a || req_b;
               O_CGS_B <= req_a || req_b;
            end
            sltc_pkg::SREQ_FORCE: begin
               O_CGS_A <= 1'b1;
               O_CGS_B <= 1'b1;
            end
            default: begin
               O_CGS_A <= 1'b0;
               O_CGS_B <= 1'b0;
            end
         endcase
      end
   end

   // symbol path: bypass, then invert, then mirror
   always_comb begin
      sym = ctl2[2] ? {2'b00, I_OCTET} : I_ENC_SYMBOL;
      if (ctl2[1]) begin
         sym = ~sym;
      end
      if (ctl2[0]) begin
         sym = {<<{sym}};
      end
   end

   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         O_LANE_A_SERIAL_OUT <= 10'h000;
         O_LINK_RESET <= 1'b0;
         O_TAIL_BIT <= 1'b0;
      end else begin
         O_LINK_RESET <= ctl1[0];
         O_LANE_A_SERIAL_OUT <= ctl1[0] ? 10'h000 : sym;
         O_TAIL_BIT <= ctl1[6] && !ctl1[0] && lfsr[30];
      end
   end

   // pseudo-random sources; held while the link is powered down
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         lfsr <= sltc_pkg::LFSR_SEED;
         pn9 <= sltc_pkg::PN9_SEED;
      end else if (!ctl1[0]) begin
         lfsr <= {lfsr[29:0], lfsr[30] ^ lfsr[27]};
         pn9 <= {pn9[7:0], pn9[8] ^ pn9[4]};
      end
   end

   // test generator
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         O_TEST_WORD <= 16'h0000;
         O_TEST_AT_SYMBOL <= 1'b0;
         tg_phase <= 1'b0;
         ramp <= 16'h0000;
         pat_idx <= 2'h0;
         pat_done <= 1'b0;
      end else begin
         O_TEST_AT_SYMBOL <= ctl3[5:4] == sltc_pkg::INJ_SYMBOL;
         tg_phase <= !tg_phase;
         ramp <= ramp + 16'h0001;
         if (ctl3[2:0] == sltc_pkg::TG_USER_REPEAT ||
             ctl3[2:0] == sltc_pkg::TG_USER_ONCE) begin
            pat_idx <= pat_idx + 2'h1;
            if (&pat_idx) begin
               pat_done <= 1'b1;
            end
         end else begin
            pat_idx <= 2'h0;
            pat_done <= 1'b0;
         end
         case (ctl3[2:0])
            sltc_pkg::TG_NORMAL: O_TEST_WORD <= 16'h0000;
            sltc_pkg::TG_CHECKER: O_TEST_WORD <= tg_phase ?
               ~sltc_pkg::TG_CHECK_WORD : sltc_pkg::TG_CHECK_WORD;
            sltc_pkg::TG_TOGGLE: O_TEST_WORD <= tg_phase ?
               16'h0000 : sltc_pkg::TG_ONES;
            sltc_pkg::TG_PN_LONG: O_TEST_WORD <= lfsr[15:0];
            sltc_pkg::TG_PN_SHORT: O_TEST_WORD <= {pn9[6:0], pn9};
            sltc_pkg::TG_RAMP: O_TEST_WORD <= ramp;
            default: begin
               if (pat_done && ctl3[2:0] == sltc_pkg::TG_USER_ONCE) begin
                  O_TEST_WORD <= 16'h0000;
               end else begin
                  case (pat_idx)
                     2'h0: O_TEST_WORD <= sltc_pkg::USER_PAT1;
                     2'h1: O_TEST_WORD <= sltc_pkg::USER_PAT2;
                     2'h2: O_TEST_WORD <= sltc_pkg::USER_PAT3;
                     default: O_TEST_WORD <= sltc_pkg::USER_PAT4;
                  endcase
               end
            end
         endcase
      end
   end

   // configuration image for the transmit datapath
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         O_LINK_CFG <= '0;
      end else begin
         O_LINK_CFG <= '{tail_en: ctl1[6], test_sample_en: ctl1[5],
            lane_sync_en: ctl1[4], ilas_mode: ctl1[3:2],
            fac_disable: ctl1[1], powered_down: ctl1[0],
            cmos_sel: ctl2[4], bypass: ctl2[2], invert: ctl2[1],
            mirror: ctl2[0], chk_disable: ctl3[7],
            inject_sel: ctl3[5:4], test_mode: ctl3[2:0],
            ilas_repeat: repeat_cnt, device_id: link_device_id, bank_id: link_bank_id,
            lane0_id: lid0, lane1_id: lid1, scrambler_enable: scr_en,
            two_lanes: two_lanes, two_conv: two_conv,
            k_minus_one: kreg, lane_assign: lane_asg};
      end
   end

   property p_div_gate;
      @(posedge I_CLOCK) disable iff (!rst_n)
      O_DIV_SYNC |-> $past(sync_ctrl[0]) && $past(sync_ctrl[1]);
   endproperty
   a_div_gate: assert property (p_div_gate)
      else $error("divider sync without both enables");

   property p_next_only;
      @(posedge I_CLOCK) disable iff (!rst_n)
      (sync_edge && (&sync_ctrl) && !wr) |=> !sync_ctrl[1];
   endproperty
   a_next_only: assert property (p_next_only)
      else $error("divider enable did not clear");

   property p_quick_reads_zero;
      @(posedge I_CLOCK) disable iff (!rst_n)
      (I_REG_RE && I_REG_ADDR == sltc_pkg::ADDR_QUICK) |=> O_REG_RDATA == 0;
   endproperty
   a_quick_reads_zero: assert property (p_quick_reads_zero)
      else $error("quick configure read not zero");

   property p_preset_two;
      @(posedge I_CLOCK) disable iff (!rst_n)
      (wr && I_REG_ADDR == sltc_pkg::ADDR_QUICK &&
       qc == sltc_pkg::QC_ONE_LINK_TWO_LANES) |=> ##1
      O_LINK_CFG.lane_assign == sltc_pkg::LANE_ASG_TWO_LANE_A &&
      O_LINK_CFG.two_lanes && O_LINK_CFG.lane_sync_en;
   endproperty
   a_preset_two: assert property (p_preset_two)
      else $error("two lane preset not applied");

   property p_lane_reserved;
      @(posedge I_CLOCK) disable iff (!rst_n)
      lane_asg <= sltc_pkg::LANE_ASG_MAX;
   endproperty
   a_lane_reserved: assert property (p_lane_reserved)
      else $error("reserved lane assignment stored");

   property p_power_down;
      @(posedge I_CLOCK) disable iff (!rst_n)
      ctl1[0] |=> O_LINK_RESET && !O_CGS_A && !O_CGS_B && !O_TAIL_BIT;
   endproperty
   a_power_down: assert property (p_power_down)
      else $error("link active while powered down");

   property p_force_sync;
      @(posedge I_CLOCK) disable iff (!rst_n)
      (ctl2[7:6] == sltc_pkg::SREQ_FORCE && !ctl1[0]) |=> O_CGS_A && O_CGS_B;
   endproperty
   a_force_sync: assert property (p_force_sync)
      else $error("forced code group sync missing");

   property p_bypass;
      @(posedge I_CLOCK) disable iff (!rst_n)
      (ctl2[2:0] == 3'h4 && !ctl1[0]) |=> O_LANE_A_SERIAL_OUT[9:8] == 2'h0;
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("bypass top bits not zero");

   property p_f_value;
      @(posedge I_CLOCK) disable iff (!rst_n)
      (I_REG_RE && I_REG_ADDR == sltc_pkg::ADDR_F) |=>
      O_REG_RDATA == ($past(two_conv) && !$past(two_lanes) ? 8'h04 : 8'h02);
   endproperty
   a_f_value: assert property (p_f_value)
      else $error("octets per frame wrong");
endmodule

// >>> sltc_top_test.sv
// Purpose: register level checks of the link transmit configuration
// Assumes: strobes are one-cycle pulses, read data one cycle late
// Notes: presets run last since they rewrite link control fields
`timescale 1ns/1ps
module sltc_top_test;
   logic clk, rst_n, we, re, pin, want_a, act_hi, req_a, req_b;
   logic [7:0] addr, wdata, rdata, octet, v;
   logic [9:0] sym, lane_out, e;
   logic div_sync, cgs_a, cgs_b, link_rst, at_sym, tail;
   logic [15:0] tword;
   sltc_pkg::sltc_link_cfg_type cfg;
   logic [7:0] ia[6] = '{8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h6E};
   logic [7:0] iv[6] = '{8'hFF, 8'hA5, 8'h0A, 8'h15, 8'h0B, 8'h01};
   logic [7:0] ec[5] = '{8'h00, 8'h02, 8'h01, 8'h03, 8'h04};
   logic [7:0] sc[5] = '{8'h00, 8'h40, 8'h80, 8'hC0, 8'h20};
   logic sa[5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
   logic [1:0] sx[5] = '{2'h2, 2'h3, 2'h3, 2'h0, 2'h2};
   logic [7:0] sy[5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07};
   int sn[5] = '{0, 0, 0, 2, 1};
   int n_fail = 0;
   int total_checks = 0;
   int n_div = 0;
   int cyc = 0;
   sltc_top sltc_top_inst (.I_CLOCK(clk), .I_RST_N(rst_n),
      .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .I_REG_WE(we),
      .I_REG_RE(re), .I_SYNC_PIN(pin), .I_LINK_A_SYNC_REQUEST(req_a),
      .I_LINK_B_SYNC_REQUEST(req_b), .I_OCTET(octet),
      .I_ENC_SYMBOL(sym), .O_REG_RDATA(rdata), .O_DIV_SYNC(div_sync),
      .O_CGS_A(cgs_a), .O_CGS_B(cgs_b), .O_LINK_RESET(link_rst),
      .O_TAIL_BIT(tail), .O_LANE_A_SERIAL_OUT(lane_out),
      .O_TEST_WORD(tword), .O_TEST_AT_SYMBOL(at_sym), .O_LINK_CFG(cfg));
   sltc_sync_rx sltc_sync_rx_inst (.i_clock(clk), .i_want_a(want_a),
      .i_want_b(1'b0), .i_active_high(act_hi), .o_req_a(req_a),
      .o_req_b(req_b));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task close_out();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // a hang costs a mismatch rather than a silent stall
   always @(posedge clk) begin
      cyc++;
      if (div_sync === 1'b1) n_div++;
      if (cyc == 3000) begin
         n_fail++;
         close_out();
      end
   end
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
   endtask
   task rc(input logic [7:0] a, input logic [7:0] x);
      @(posedge clk);
      addr <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      wt(1);
      chk(rdata, x);
   endtask
   // pin must sit low a few cycles so the next rise is seen
   task pulse();
      @(posedge clk);
      pin <= 1'b1;
      repeat (4) @(posedge clk);
      pin <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   initial begin
      {rst_n, we, re, pin, want_a, act_hi} = 6'h00;
      addr = 8'h00;
      wdata = 8'h00;
      octet = 8'h5A;
      sym = 10'h2C5;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rc(8'h6E, 8'h80);
      rc(8'h70, 8'h0F);
      for (int i = 0; i < 6; i++) begin
         wr(ia[i], iv[i]);
         rc(ia[i], iv[i]);
      end
      $display("test identifiers done");
      wr(8'h60, 8'h01);
      wt(3);
      chk(link_rst, 1'b1);
      chk(lane_out, 10'h000);
      wr(8'h60, 8'h00);
      wt(3);
      chk(link_rst, 1'b0);
      chk(tail, 1'b0);
      // tail enable: the pseudo-random fill must show both levels
      wr(8'h60, 8'h40);
      v = 8'h00;
      repeat (64) begin
         wt(1);
         v = v | {6'h00, tail, ~tail};
      end
      chk(v, 8'h03);
      wr(8'h60, 8'h00);
      wt(3);
      chk(tail, 1'b0);
      for (int i = 0; i < 5; i++) begin
         wr(8'h61, ec[i]);
         wt(3);
         e = ec[i][2] ? {2'b00, octet} : sym;
         if (ec[i][1]) e = ~e;
         if (ec[i][0]) e = {<<{e}};
         chk(lane_out, e);
      end
      $display("test symbol path done");
      for (int i = 0; i < 5; i++) begin
         wr(8'h61, sc[i]);
         want_a <= sa[i];
         act_hi <= sc[i][5];
         wt(10);
         chk({cgs_a, cgs_b}, sx[i]);
      end
      $display("test sync request done");
      for (int i = 0; i < 5; i++) begin
         wr(8'h3A, sy[i]);
         n_div = 0;
         pulse();
         pulse();
         chk(n_div, sn[i]);
      end
      rc(8'h3A, 8'h05);
      $display("test divider sync done");
      wr(8'h62, 8'h15);
      wt(3);
      chk(at_sym, 1'b1);
      for (int i = 0; i < 10 && tword !== 16'h1111; i++) wt(1);
      for (int i = 2; i < 5; i++) begin
         wt(1);
         chk(tword, 16'(16'h1111 * i));
      end
      wr(8'h62, 8'h25);
      rc(8'h62, 8'h15);
      $display("test generator done");
      wr(8'h5E, 8'h02);
      rc(8'h5E, 8'h00);
      rc(8'h5F, 8'h02);
      rc(8'h60, 8'h14);
      rc(8'h6F, 8'h02);
      chk(cfg.lane_assign, 4'h2);
      wr(8'h60, 8'h08);
      rc(8'h60, 8'h14);
      wr(8'h5F, 8'h06);
      wr(8'h5E, 8'h04);
      rc(8'h5F, 8'h02);
      wr(8'h5E, 8'h03);
      rc(8'h6F, 8'h04);
      rc(8'h70, 8'h07);
      rc(8'h5F, 8'h00);
      wr(8'h5E, 8'h01);
      rc(8'h6F, 8'h02);
      rc(8'h70, 8'h0F);
      $display("test presets done");
      close_out();
   end
endmodule
